// *** rtl/tubw_pkg.sv ***
// Constants shared by the baud and wake timer unit
package tubw_pkg;
	// ----------------------------------------
	// Clock and prescale
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam logic [1:0] SCALE_DIV12 = 2'h0;
	localparam logic [1:0] SCALE_DIV4 = 2'h1;
	localparam logic [1:0] SCALE_DIV48 = 2'h2;
	localparam logic [1:0] SCALE_EXT8 = 2'h3;
	localparam logic [5:0] DIV4_LAST = 6'h03;
	localparam logic [5:0] DIV12_LAST = 6'h0b;
	localparam logic [5:0] DIV48_LAST = 6'h2f;
	localparam logic [2:0] EXT_DIV_LAST = 3'h7;
	// ----------------------------------------
	// Wake timer clock select and control bits
	// ----------------------------------------
	localparam logic [1:0] WCLK_SYS = 2'h0;
	localparam logic [1:0] WCLK_DIV12 = 2'h1;
	localparam logic [1:0] WCLK_EXT8 = 2'h2;
	localparam logic [1:0] WCLK_LFO8 = 2'h3;
	localparam int unsigned CTL_OVF_HI = 7;
	localparam int unsigned CTL_OVF_LO = 6;
	localparam int unsigned CTL_LO_IRQ_EN = 5;
	localparam int unsigned CTL_RUN = 2;
	localparam int unsigned CTL_SPLIT = 3;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [15:0] WAKE_RESET = 16'h0000;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [15:0] WORD_ONES = 16'hffff;
	localparam logic [1:0] SYNC_CLOCKS = 2'h3;
	// ----------------------------------------
	// Basic timer modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		TUBW_M13,
		TUBW_M16,
		TUBW_M8R,
		TUBW_MOFF
	} tubw_mode_t;
endpackage : tubw_pkg

// *** rtl/tubw_edge.sv ***
// Edge and level sampler for a slow count or clock input
`timescale 1ns/100ps
`default_nettype none
module tubw_edge (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Sampled input
	input wire logic sig_in,
	// Results
	output logic fall_out,
	output logic rise_out
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;

	// ----------------------------------------
	// Two stage sampler, third for edges
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
		end else begin
			s1_ff <= sig_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fall_out <= 1'b0;
			rise_out <= 1'b0;
		end else begin
			fall_out <= s3_ff & ~s2_ff;
			rise_out <= ~s3_ff & s2_ff;
		end
	end
endmodule : tubw_edge
`default_nettype wire

// *** rtl/tubw_top.sv ***
// Baud rate timer and suspend wake timer
// Functional notes
// - Serial bit clock from first timer, 8-bit reload; transmit uses low byte.
// - Transmit and receive timer overflows divided by two for bit rates.
// - Hidden receive copy counts when first timer runs, same reload byte.
// - Start condition on receive pin forces receive copy reload.
// - Overflow rate is clock over 256 minus reload; bit rate half.
// - First timer clock: system_clock, /4, /12, /48, ext osc /8, count pin.
// - Per-timer select bits choose system_clock or shared prescaled clock.
// - Counter mode increments on falling edge of sampled count input.
// - 16-bit mode like 13-bit mode but uses all 16 bits.
// - Wake timer 16-bit from two bytes; bit 3 selects split mode.
// - Wake timer clock: system_clock, system_clock/12, ext osc /8, lfo /8.
// - Divided slow clocks synchronized outside suspend, direct in suspend.
// - Wake timer counts in suspend; overflow wakes the device.
// - Sync-pending flag up to three timer clocks after foreign wake.
// - 16-bit wrap loads reload pair and sets high overflow flag bit 7.
// - With extended enable bit 7, interrupt on every 16-bit overflow.
// - With low-byte enable bit 5 too, interrupt on low byte wrap.
`timescale 1ns/100ps
`default_nettype none
module tubw_top
	import tubw_pkg::*;
(
	// Clock and reset
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	// Basic timer configuration
	input wire logic [1:0] TIMER0_MODE_IN,
	input wire logic [1:0] TIMER1_MODE_IN,
	input wire logic TIMER0_RUN_IN,
	input wire logic TIMER1_RUN_IN,
	input wire logic TIMER0_COUNTER_IN,
	input wire logic TIMER1_COUNTER_IN,
	input wire logic [1:0] TIMER_CLOCK_SELECT_BITS_IN,
	input wire logic [1:0] PRESCALE_SELECT_FIELD_IN,
	input wire logic [7:0] FIRST_TIMER_RELOAD_BYTE_IN,
	// Pins and slow clocks
	input wire logic COUNT_INPUT_ZERO_IN,
	input wire logic COUNT_INPUT_ONE_IN,
	input wire logic RX_PIN_IN,
	input wire logic EXT_OSC_IN,
	input wire logic LOW_FREQ_OSCILLATOR_IN,
	// Wake timer configuration
	input wire logic [7:0] WAKE_TIMER_CONTROL_IN,
	input wire logic [1:0] WAKE_CLOCK_SELECT_IN,
	input wire logic [7:0] WAKE_TIMER_RELOAD_LOW_IN,
	input wire logic [7:0] WAKE_TIMER_RELOAD_HIGH_IN,
	input wire logic EXTENDED_IRQ_ENABLE_IN,
	input wire logic SUSPEND_IN,
	input wire logic FOREIGN_WAKE_IN,
	input wire logic CLEAR_OVF_HI_IN,
	input wire logic CLEAR_OVF_LO_IN,
	// Serial side
	output logic TX_BIT_CLOCK_OUT,
	output logic RX_BIT_CLOCK_OUT,
	output logic TX_BIT_TICK_OUT,
	output logic RX_BIT_TICK_OUT,
	// Timer state
	output logic [15:0] TIMER0_COUNT_OUT,
	output logic [15:0] TIMER1_COUNT_OUT,
	output logic [7:0] WAKE_TIMER_LOW_BYTE_OUT,
	output logic [7:0] WAKE_TIMER_HIGH_BYTE_OUT,
	output logic OVF_HI_FLAG_OUT,
	output logic OVF_LO_FLAG_OUT,
	output logic WAKE_IRQ_OUT,
	output logic WAKE_EVENT_OUT,
	output logic TIMER_SYNC_PENDING_OUT
);
	logic [5:0] pre_cnt_ff;
	logic pre4, pre12, pre48;
	logic [2:0] ext_cnt_ff;
	logic ext8_ff;
	logic [2:0] lfo_cnt_ff;
	logic lfo8_ff;
	logic ext_rise, lfo_rise, c0_fall, c1_fall, rx_fall;
	logic scaled_tick;
	logic [1:0] tick;
	logic [15:0] cnt_ff [2];
	logic [1:0] ovf;
	logic [7:0] rx_cnt_ff;
	logic rx_ovf;
	logic tx_half_ff, rx_half_ff;
	logic w_tick;
	logic lfo8_d_ff;
	logic ext8_d_ff;
	logic [1:0] sync_cnt_ff;
	logic susp_d_ff;
	logic split;
	logic lo_wrap, hi_wrap;

	// ----------------------------------------
	// Prescaler shared by the basic timers
	// ----------------------------------------
	// system clock dividers
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN || pre_cnt_ff == DIV48_LAST)
			pre_cnt_ff <= 6'h00;
		else
			pre_cnt_ff <= pre_cnt_ff + 6'h01;
	end
	assign pre4 = (pre_cnt_ff[1:0] == DIV4_LAST[1:0]);
	assign pre12 = (pre_cnt_ff == DIV12_LAST) || (pre_cnt_ff == 6'h17) ||
		(pre_cnt_ff == 6'h23) || (pre_cnt_ff == DIV48_LAST);
	assign pre48 = (pre_cnt_ff == DIV48_LAST);

	// Slow clocks sampled; edges are counted on the system clock
	tubw_edge u_ext (
		.clk_in(MCLK_IN), .rst_in(RST_IN), .sig_in(EXT_OSC_IN),
		.fall_out(), .rise_out(ext_rise));
	tubw_edge u_lfo (
		.clk_in(MCLK_IN), .rst_in(RST_IN), .sig_in(LOW_FREQ_OSCILLATOR_IN),
		.fall_out(), .rise_out(lfo_rise));
	// count inputs sampled, falling edge counts
	// two-cycle hold assumed by the sampler
	tubw_edge u_c0 (
		.clk_in(MCLK_IN), .rst_in(RST_IN), .sig_in(COUNT_INPUT_ZERO_IN),
		.fall_out(c0_fall), .rise_out());
	tubw_edge u_c1 (
		.clk_in(MCLK_IN), .rst_in(RST_IN), .sig_in(COUNT_INPUT_ONE_IN),
		.fall_out(c1_fall), .rise_out());
	tubw_edge u_rx (
		.clk_in(MCLK_IN), .rst_in(RST_IN), .sig_in(RX_PIN_IN),
		.fall_out(rx_fall), .rise_out());

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			ext_cnt_ff <= 3'h0;
			ext8_ff <= 1'b0;
		end else if (ext_rise) begin
			ext_cnt_ff <= ext_cnt_ff + 3'h1;
			ext8_ff <= (ext_cnt_ff == EXT_DIV_LAST);
		end else begin
			ext8_ff <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			lfo_cnt_ff <= 3'h0;
			lfo8_ff <= 1'b0;
		end else if (lfo_rise) begin
			lfo_cnt_ff <= lfo_cnt_ff + 3'h1;
			lfo8_ff <= (lfo_cnt_ff == EXT_DIV_LAST);
		end else begin
			lfo8_ff <= 1'b0;
		end
	end

	// prescale field picks the shared scaled clock
	always_comb begin
		case (PRESCALE_SELECT_FIELD_IN)
			SCALE_DIV12: scaled_tick = pre12;
			SCALE_DIV4: scaled_tick = pre4;
			SCALE_DIV48: scaled_tick = pre48;
			default: scaled_tick = ext8_ff;
		endcase
	end

	// ----------------------------------------
	// Basic timers zero and one
	// ----------------------------------------
	// per-timer select: system clock or scaled clock
	assign tick[0] = TIMER0_RUN_IN & (TIMER0_COUNTER_IN ? c0_fall :
		(TIMER_CLOCK_SELECT_BITS_IN[0] | scaled_tick));
	assign tick[1] = TIMER1_RUN_IN & (TIMER1_COUNTER_IN ? c1_fall :
		(TIMER_CLOCK_SELECT_BITS_IN[1] | scaled_tick));

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_basic
			tubw_mode_t mode;
			assign mode = tubw_mode_t'(gi == 0 ? TIMER0_MODE_IN :
				TIMER1_MODE_IN);
			always_comb begin
				case (mode)
					TUBW_M13: ovf[gi] = tick[gi] &&
						cnt_ff[gi][15:8] == BYTE_ONES &&
						cnt_ff[gi][4:0] == 5'h1f;
					TUBW_M16: ovf[gi] = tick[gi] && cnt_ff[gi] == WORD_ONES;
					TUBW_M8R: ovf[gi] = tick[gi] &&
						cnt_ff[gi][7:0] == BYTE_ONES;
					default: ovf[gi] = 1'b0;
				endcase
			end
			always_ff @(posedge MCLK_IN) begin
				if (RST_IN) begin
					cnt_ff[gi] <= WAKE_RESET;
				end else if (tick[gi]) begin
					case (mode)
						// 13-bit: five-bit prescale below high byte
						TUBW_M13: begin
							cnt_ff[gi][7:0] <= {3'h0,
								cnt_ff[gi][4:0] + 5'h01};
							if (cnt_ff[gi][4:0] == 5'h1f)
								cnt_ff[gi][15:8] <= cnt_ff[gi][15:8] +
									8'h01;
						end
						// same as 13-bit with all 16 bits
						TUBW_M16: cnt_ff[gi] <= cnt_ff[gi] + 16'h0001;
						// eight-bit count reloading from high byte
						TUBW_M8R: begin
							if (cnt_ff[gi][7:0] == BYTE_ONES)
								cnt_ff[gi][7:0] <= cnt_ff[gi][15:8];
							else
								cnt_ff[gi][7:0] <= cnt_ff[gi][7:0] + 8'h01;
							if (gi == 1)
								cnt_ff[gi][15:8] <=
									FIRST_TIMER_RELOAD_BYTE_IN;
						end
						default: cnt_ff[gi] <= cnt_ff[gi];
					endcase
				end else if (gi == 1 && mode == TUBW_M8R) begin
					cnt_ff[gi][15:8] <= FIRST_TIMER_RELOAD_BYTE_IN;
				end
			end
		end
	endgenerate

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			TIMER0_COUNT_OUT <= WAKE_RESET;
			TIMER1_COUNT_OUT <= WAKE_RESET;
		end else begin
			TIMER0_COUNT_OUT <= cnt_ff[0];
			TIMER1_COUNT_OUT <= cnt_ff[1];
		end
	end

	// ----------------------------------------
	// Receive copy timer and bit clocks
	// ----------------------------------------
	// hidden copy counts with timer one, same reload
	// start edge forces reload, aligning reception
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN)
			rx_cnt_ff <= 8'h00;
		else if (rx_fall)
			rx_cnt_ff <= FIRST_TIMER_RELOAD_BYTE_IN;
		else if (tick[1])
			rx_cnt_ff <= (rx_cnt_ff == BYTE_ONES) ?
				FIRST_TIMER_RELOAD_BYTE_IN : rx_cnt_ff + 8'h01;
	end
	assign rx_ovf = tick[1] && !rx_fall && rx_cnt_ff == BYTE_ONES;

	// bit rate is half of clock over 256 minus reload
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			tx_half_ff <= 1'b0;
			rx_half_ff <= 1'b0;
			TX_BIT_TICK_OUT <= 1'b0;
			RX_BIT_TICK_OUT <= 1'b0;
		end else begin
			tx_half_ff <= tx_half_ff ^ ovf[1];
			rx_half_ff <= rx_fall ? 1'b0 : rx_half_ff ^ rx_ovf;
			TX_BIT_TICK_OUT <= ovf[1] & tx_half_ff;
			RX_BIT_TICK_OUT <= rx_ovf & rx_half_ff;
		end
	end
	assign TX_BIT_CLOCK_OUT = tx_half_ff;
	assign RX_BIT_CLOCK_OUT = rx_half_ff;

	// ----------------------------------------
	// Wake timer
	// ----------------------------------------
	// divided slow ticks get one extra register stage unless suspended
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			lfo8_d_ff <= 1'b0;
			ext8_d_ff <= 1'b0;
		end else begin
			lfo8_d_ff <= lfo8_ff;
			ext8_d_ff <= ext8_ff;
		end
	end

	// suspend takes the divided tick without the extra stage
	always_comb begin
		case (WAKE_CLOCK_SELECT_IN)
			WCLK_SYS: w_tick = 1'b1;
			WCLK_DIV12: w_tick = pre12;
			WCLK_EXT8: w_tick = SUSPEND_IN ? ext8_ff : ext8_d_ff;
			default: w_tick = SUSPEND_IN ? lfo8_ff : lfo8_d_ff;
		endcase
		w_tick = w_tick & WAKE_TIMER_CONTROL_IN[CTL_RUN];
	end

	assign split = WAKE_TIMER_CONTROL_IN[CTL_SPLIT];
	assign lo_wrap = w_tick && WAKE_TIMER_LOW_BYTE_OUT == BYTE_ONES;
	assign hi_wrap = w_tick && WAKE_TIMER_HIGH_BYTE_OUT == BYTE_ONES &&
		(split || WAKE_TIMER_LOW_BYTE_OUT == BYTE_ONES);

	// split halves reload from their own bytes
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			WAKE_TIMER_LOW_BYTE_OUT <= 8'h00;
			WAKE_TIMER_HIGH_BYTE_OUT <= 8'h00;
		end else if (w_tick) begin
			WAKE_TIMER_LOW_BYTE_OUT <= (split ? lo_wrap : hi_wrap) ?
				WAKE_TIMER_RELOAD_LOW_IN : WAKE_TIMER_LOW_BYTE_OUT + 8'h01;
			if (hi_wrap)
				WAKE_TIMER_HIGH_BYTE_OUT <= WAKE_TIMER_RELOAD_HIGH_IN;
			else if (split || lo_wrap)
				WAKE_TIMER_HIGH_BYTE_OUT <= WAKE_TIMER_HIGH_BYTE_OUT + 8'h01;
		end
	end

	// high overflow flag; set wins over clear
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			OVF_HI_FLAG_OUT <= 1'b0;
			OVF_LO_FLAG_OUT <= 1'b0;
		end else begin
			OVF_HI_FLAG_OUT <= hi_wrap | (OVF_HI_FLAG_OUT & ~CLEAR_OVF_HI_IN);
			OVF_LO_FLAG_OUT <= (lo_wrap &
				(split | WAKE_TIMER_CONTROL_IN[CTL_LO_IRQ_EN])) |
				(OVF_LO_FLAG_OUT & ~CLEAR_OVF_LO_IN);
		end
	end

	// low byte wraps add interrupts when enabled
	// overflow in suspend wakes the device
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			WAKE_IRQ_OUT <= 1'b0;
			WAKE_EVENT_OUT <= 1'b0;
		end else begin
			WAKE_IRQ_OUT <= EXTENDED_IRQ_ENABLE_IN & (hi_wrap | (lo_wrap &
				WAKE_TIMER_CONTROL_IN[CTL_LO_IRQ_EN]));
			WAKE_EVENT_OUT <= SUSPEND_IN & hi_wrap;
		end
	end

	// sync pending for three timer clocks after foreign wake
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			susp_d_ff <= 1'b0;
			sync_cnt_ff <= 2'h0;
			TIMER_SYNC_PENDING_OUT <= 1'b0;
		end else begin
			susp_d_ff <= SUSPEND_IN;
			if (susp_d_ff && !SUSPEND_IN && FOREIGN_WAKE_IN)
				sync_cnt_ff <= SYNC_CLOCKS;
			else if (w_tick && sync_cnt_ff != 2'h0)
				sync_cnt_ff <= sync_cnt_ff - 2'h1;
			TIMER_SYNC_PENDING_OUT <= (susp_d_ff && !SUSPEND_IN &&
				FOREIGN_WAKE_IN) || (sync_cnt_ff > 2'h1) ||
				(sync_cnt_ff == 2'h1 && !w_tick);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_rx_reload: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		rx_fall |=> rx_cnt_ff == $past(FIRST_TIMER_RELOAD_BYTE_IN))
		else $error("receive copy not reloaded on start");
	a_tx_halve: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		ovf[1] |=> tx_half_ff != $past(tx_half_ff))
		else $error("transmit bit clock did not toggle");
	a_wake_reload: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(hi_wrap && !split) |=> {WAKE_TIMER_HIGH_BYTE_OUT,
		WAKE_TIMER_LOW_BYTE_OUT} == {$past(WAKE_TIMER_RELOAD_HIGH_IN),
		$past(WAKE_TIMER_RELOAD_LOW_IN)})
		else $error("wake timer reload pair not loaded");
	a_ovf_flag: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		hi_wrap |=> OVF_HI_FLAG_OUT)
		else $error("high overflow flag not set");
	a_irq_ovf: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(hi_wrap && EXTENDED_IRQ_ENABLE_IN) |=> WAKE_IRQ_OUT)
		else $error("overflow interrupt missing");
	a_irq_low: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(lo_wrap && EXTENDED_IRQ_ENABLE_IN &&
		WAKE_TIMER_CONTROL_IN[CTL_LO_IRQ_EN]) |=> WAKE_IRQ_OUT)
		else $error("low byte interrupt missing");
	a_wake_ev: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		WAKE_EVENT_OUT |-> $past(SUSPEND_IN) && $past(hi_wrap))
		else $error("wake without suspended overflow");
	a_count_fall: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(TIMER0_RUN_IN && TIMER0_COUNTER_IN && !c0_fall) |=>
		cnt_ff[0] == $past(cnt_ff[0]))
		else $error("counter moved without falling edge");
	a_split_rel: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
		(split && lo_wrap) |=>
		WAKE_TIMER_LOW_BYTE_OUT == $past(WAKE_TIMER_RELOAD_LOW_IN))
		else $error("split low half not reloaded");
endmodule : tubw_top
`default_nettype wire

// *** verification/tubw_partner.sv ***
// Far-side model driving the count pin and the receive pin
`timescale 1ns/100ps
`default_nettype none
module tubw_partner (
	// Clock and request
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [3:0] falls_in,
	// Pins
	output logic pin_out,
	output logic rx_out
);
	logic [5:0] cnt_ff = 6'h00;
	always @(posedge clk_in) begin
		if (go_in)
			cnt_ff <= {falls_in, 2'b00} - 6'h01;
		else if (cnt_ff != 6'h00)
			cnt_ff <= cnt_ff - 6'h01;
	end
	// Each level two clocks, last low too
	assign pin_out = ~cnt_ff[1];
	// Start condition while busy
	assign rx_out = (cnt_ff == 6'h00);
endmodule : tubw_partner
`default_nettype wire

// *** verification/test_tubw_top.sv ***
// Self-checking bench for the baud and wake timer unit
`timescale 1ns/100ps
`default_nettype none
module test_tubw_top;
	import tubw_pkg::*;
	logic mclk = 0, rst = 1, t0r = 0, t1r = 0, t0c = 0, t1c = 0, c1 = 1;
	logic eo = 0, low_freq_oscillator = 0, xie = 0, susp = 0, fw = 0, clh = 0, cll = 0;
	logic go = 0, c0, rx;
	logic [1:0] t0m = 2'h3, t1m = 2'h3, csel = 2'h0, psel = 2'h0, wsel = 2'h0;
	logic [3:0] nf = 4'h0;
	logic [7:0] rl1 = 8'h00, wctl = 8'h00, wrl = 8'h00, wrh = 8'h00;
	logic txc, rxc, txt, rxt, fhi, flo, irq, wev, spend;
	logic [15:0] cnt0, cnt1;
	logic [7:0] wlo, whi;
	int n_mismatch = 0, comparisons = 0;
	tubw_top tubw_top_inst (.MCLK_IN(mclk), .RST_IN(rst),
		.TIMER0_MODE_IN(t0m), .TIMER1_MODE_IN(t1m), .TIMER0_RUN_IN(t0r),
		.TIMER1_RUN_IN(t1r), .TIMER0_COUNTER_IN(t0c), .TIMER1_COUNTER_IN(t1c),
		.TIMER_CLOCK_SELECT_BITS_IN(csel), .PRESCALE_SELECT_FIELD_IN(psel),
		.FIRST_TIMER_RELOAD_BYTE_IN(rl1), .COUNT_INPUT_ZERO_IN(c0),
		.COUNT_INPUT_ONE_IN(c1), .RX_PIN_IN(rx), .EXT_OSC_IN(eo),
		.LOW_FREQ_OSCILLATOR_IN(low_freq_oscillator), .WAKE_TIMER_CONTROL_IN(wctl),
		.WAKE_CLOCK_SELECT_IN(wsel), .WAKE_TIMER_RELOAD_LOW_IN(wrl),
		.WAKE_TIMER_RELOAD_HIGH_IN(wrh), .EXTENDED_IRQ_ENABLE_IN(xie),
		.SUSPEND_IN(susp), .FOREIGN_WAKE_IN(fw), .CLEAR_OVF_HI_IN(clh),
		.CLEAR_OVF_LO_IN(cll), .TX_BIT_CLOCK_OUT(txc), .RX_BIT_CLOCK_OUT(rxc),
		.TX_BIT_TICK_OUT(txt), .RX_BIT_TICK_OUT(rxt), .TIMER0_COUNT_OUT(cnt0),
		.TIMER1_COUNT_OUT(cnt1), .WAKE_TIMER_LOW_BYTE_OUT(wlo),
		.WAKE_TIMER_HIGH_BYTE_OUT(whi), .OVF_HI_FLAG_OUT(fhi),
		.OVF_LO_FLAG_OUT(flo), .WAKE_IRQ_OUT(irq), .WAKE_EVENT_OUT(wev),
		.TIMER_SYNC_PENDING_OUT(spend));
	tubw_partner tubw_partner_inst (.clk_in(mclk), .go_in(go),
		.falls_in(nf), .pin_out(c0), .rx_out(rx));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		forever #5 mclk = ~mclk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Cycles between two bit ticks, sampled after each edge settles
	task automatic gap(input bit use_rx, output int n);
		int w;
		w = 0;
		do begin
			step(1);
			w++;
		end while (((use_rx ? rxt : txt) !== 1'b1) && w < 3000);
		n = 0;
		do begin
			step(1);
			n++;
		end while (((use_rx ? rxt : txt) !== 1'b1) && n < 3000);
	endtask : gap
	// Slow oscillator pins rise every four system clocks
	task automatic osc(input int n);
		repeat (n) begin
			eo = 1'b1;
			low_freq_oscillator = 1'b1;
			step(2);
			eo = 1'b0;
			low_freq_oscillator = 1'b0;
			step(2);
		end
	endtask : osc
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_wake16();
		int w;
		bit ev;
		w = 0;
		ev = 0;
		wsel = WCLK_SYS; wrl = 8'hf0; wrh = 8'hff; xie = 1'b1; susp = 1'b1;
		wctl = 8'h24;
		// Low byte wraps interrupt first; wait for the 16-bit flag
		while (fhi !== 1'b1 && w < 70000) begin
			step(1);
			w++;
			ev = ev | (wev === 1'b1);
		end
		chk("overflow irq", 16'h0001, {15'h0, irq});
		chk("wake event", 16'h1, {15'h0, ev});
		chk("high flag", 16'h1, {15'h0, fhi});
		chk("low flag", 16'h1, {15'h0, flo});
		chk("reload pair", 16'hfff0, {whi, wlo});
		w = 0;
		do begin
			step(1);
			w++;
		end while (irq !== 1'b1 && w < 100);
		chk("irq period", 16'h0010, 16'(w));
		clh = 1'b1; step(1); clh = 1'b0; step(1);
		chk("high flag clear", 16'h0, {15'h0, fhi});
		$display("test wake16 done");
	endtask : t_wake16
	task automatic t_sync();
		int w;
		fw = 1'b1; susp = 1'b0; step(1); fw = 1'b0; step(1);
		chk("sync set", 16'h1, {15'h0, spend});
		w = 0;
		while (spend === 1'b1 && w < 10) begin
			step(1);
			w++;
		end
		chk("sync end", 16'h1, 16'(w <= 4));
		$display("test sync done");
	endtask : t_sync
	task automatic t_split();
		wctl = 8'h2c; wrl = 8'hfe; wrh = 8'hf0; step(6);
		cll = 1'b1; step(1); cll = 1'b0; step(4);
		chk("split low flag", 16'h1, {15'h0, flo});
		chk("split low range", 16'h7f, {9'h0, wlo[7:1]});
		chk("split 16 mode off", 16'h1, 16'(whi >= 8'hf0));
		wctl = 8'h00;
		$display("test split done");
	endtask : t_split
	task automatic t_slow();
		logic [15:0] v;
		susp = 1'b0;
		wsel = WCLK_LFO8;
		v = {whi, wlo};
		wctl = 8'h04;
		osc(64);
		step(6);
		wctl = 8'h00;
		chk("lfo eighths", 16'h0008, 16'({whi, wlo} - v));
		// Suspended: divided tick drives the timer directly
		susp = 1'b1;
		wsel = WCLK_EXT8;
		v = {whi, wlo};
		wctl = 8'h04;
		osc(64);
		step(6);
		wctl = 8'h00;
		chk("ext eighths", 16'h0008, 16'({whi, wlo} - v));
		$display("test slow done");
	endtask : t_slow
	task automatic t_baud();
		int n;
		int dv[3] = '{4, 12, 48};
		logic [1:0] pc[3] = '{SCALE_DIV4, SCALE_DIV12, SCALE_DIV48};
		// 8-bit reload at twice bit rate
		t1m = TUBW_M8R; t1r = 1'b1; csel = 2'b10; rl1 = 8'hfc;
		gap(1'b0, n); gap(1'b0, n);
		chk("tx gap", 16'h0008, 16'(n));
		chk("tx clock low", 16'h0000, {15'h0, txc});
		chk("reload byte", 16'h00fc, {8'h00, cnt1[15:8]});
		step(4);
		chk("tx clock high", 16'h0001, {15'h0, txc});
		gap(1'b1, n);
		chk("rx gap", 16'h0008, 16'(n));
		for (int i = 0; i < 3; i++) begin
			csel = 2'b00; psel = pc[i];
			gap(1'b0, n); gap(1'b0, n);
			chk("scaled gap", 16'(8 * dv[i]), 16'(n));
		end
		$display("test baud done");
	endtask : t_baud
	task automatic t_rxstart();
		int w;
		csel = 2'b10; step(3);
		nf = 4'h1; go = 1'b1; step(1); go = 1'b0;
		// Old phase ticks may land while the start is being sampled
		step(3);
		w = 3;
		do begin
			step(1);
			w++;
		end while (rxt !== 1'b1 && w < 40);
		chk("rx after start", 16'h000c, 16'(w));
		chk("rx clock phase", 16'h0000, {15'h0, rxc});
		$display("test rxstart done");
	endtask : t_rxstart
	task automatic t_count();
		t0m = TUBW_M16; t0c = 1'b1; t0r = 1'b1; step(4);
		chk("count idle", 16'h0, cnt0);
		nf = 4'h5; go = 1'b1; step(1); go = 1'b0; step(30);
		chk("count falls", 16'h5, cnt0);
		$display("test count done");
	endtask : t_count
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		step(4);
		rst = 1'b0;
		step(3);
		t_wake16();
		t_sync();
		t_split();
		t_slow();
		t_baud();
		t_rxstart();
		t_count();
		finish_test();
	end
	initial begin
		repeat (95000) @(posedge mclk);
		n_mismatch++;
		finish_test();
	end
endmodule : test_tubw_top
`default_nettype wire
